//--- jtp_cfg.svh
// Constants for the test access port with programming registers
`ifndef JTP_CFG_SVH
`define JTP_CFG_SVH

// ---------------------------------------------------------------
// Instruction register
// ---------------------------------------------------------------
`define JTP_IR_W 6
`define JTP_IR_CAPTURE 6'h01
`define JTP_OP_EXTEST 6'h00
`define JTP_OP_IDCODE 6'h01
`define JTP_OP_SAMPLE 6'h02
`define JTP_OP_USERCODE 6'h03
`define JTP_OP_ROW 6'h04
`define JTP_OP_COLUMN 6'h05
`define JTP_OP_PMODE 6'h06
`define JTP_OP_PROGRAM 6'h07
`define JTP_OP_ERASE 6'h08
`define JTP_OP_BYPASS 6'h3F

// ---------------------------------------------------------------
// Data registers
// ---------------------------------------------------------------
`define JTP_DR_MAX 32
`define JTP_N_IO 4
`define JTP_BSR_LEN 6'h0C
`define JTP_ID_LEN 6'h20
`define JTP_ROW_W 8
`define JTP_ROW_LEN 6'h08
`define JTP_COL_W 16
`define JTP_COL_LEN 6'h10
`define JTP_BYP_LEN 6'h01
// Identity fields, arbitrary values
`define JTP_ID_REV 4'h1
`define JTP_ID_DEV 16'h0A5C
`define JTP_ID_MFR 11'h07E
`define JTP_IDCODE {`JTP_ID_REV, `JTP_ID_DEV, `JTP_ID_MFR, 1'b1}
// User word, arbitrary default
`define JTP_USERCODE 32'h0000_0000
// Key to enter protected program mode, arbitrary
`define JTP_PASSKEY 16'hC3A5

// ---------------------------------------------------------------
// Program request buffer
// ---------------------------------------------------------------
`define JTP_FIFO_DEPTH 16
`define JTP_FIFO_W 25

`endif

//--- jtp_fifo.sv
// Program request FIFO with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none

module jtp_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output var logic in_ready,
  // Drain side
  output var logic out_valid,
  input wire logic out_ready,
  output var logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] cnt_ff;
  logic [AW:0] nxt_cnt;
  logic push;
  logic pop;
  logic [AW-1:0] nxt_rd;

  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
  assign nxt_rd = rd_ptr_ff + AW'(pop);

  // Head word registered, bypass when writing the next head
  always_ff @(posedge clk)
  begin
    if (push)
      mem_ff[wr_ptr_ff] <= in_data;
    if (push && wr_ptr_ff == nxt_rd)
      out_data <= in_data;
    else
      out_data <= mem_ff[nxt_rd];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop)
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      cnt_ff <= nxt_cnt;
      in_ready <= nxt_cnt != (AW+1)'(DEPTH);
      out_valid <= nxt_cnt != '0;
    end
  end

endmodule : jtp_fifo

`default_nettype wire

//--- jtp_pkg.sv
// Types for the test access port with programming registers
`default_nettype none

package jtp_pkg;

  typedef enum logic [3:0] {
    st_tlr, st_rti,
    st_sel_dr, st_cap_dr, st_sh_dr, st_ex1_dr,
    st_pa_dr, st_ex2_dr, st_upd_dr,
    st_sel_ir, st_cap_ir, st_sh_ir, st_ex1_ir,
    st_pa_ir, st_ex2_ir, st_upd_ir
  } jtp_state_t;

  typedef enum logic [2:0] {
    sel_byp, sel_id, sel_usr, sel_bsr, sel_row, sel_col
  } jtp_dr_sel_t;

endpackage : jtp_pkg

`default_nettype wire

//--- jtp_tap.sv
// Test access port with row, column and boundary registers
`include "jtp_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module jtp_tap (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Test access port pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  output var logic tdo,
  output var logic tdo_oe,
  // Programming strobe pin
  input wire logic prog_strobe_n,
  // Device pins and core
  input wire logic [`JTP_N_IO-1:0] pin_in,
  output var logic [`JTP_N_IO-1:0] pin_out,
  output var logic [`JTP_N_IO-1:0] pin_oe,
  input wire logic [`JTP_N_IO-1:0] core_out,
  input wire logic [`JTP_N_IO-1:0] core_oe,
  output var logic [`JTP_N_IO-1:0] core_in,
  // Programming array requests
  output var logic prog_valid,
  input wire logic prog_ready,
  output var logic [`JTP_FIFO_W-1:0] prog_word,
  output var logic prog_mode
);

  // -------------------------------------------------------------
  // Input synchronisers and edge detect
  // -------------------------------------------------------------
  localparam int SW = 4 + `JTP_N_IO;
  logic [SW-1:0] sync1_ff;
  logic [SW-1:0] sync2_ff;
  logic tck_d_ff;
  logic strb_d_ff;
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic strb_s;
  logic [`JTP_N_IO-1:0] pin_s;
  logic tck_rise;
  logic tck_fall;
  logic strb_fall;
  logic tap_rst_n;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_ff <= {{`JTP_N_IO{1'b0}}, 4'h8};
      sync2_ff <= {{`JTP_N_IO{1'b0}}, 4'h8};
      tck_d_ff <= 1'b0;
      strb_d_ff <= 1'b1;
    end
    else
    begin
      sync1_ff <= {pin_in, prog_strobe_n, tdi, tms, tck};
      sync2_ff <= sync1_ff;
      tck_d_ff <= tck_s;
      strb_d_ff <= strb_s;
    end
  end

  assign tck_s = sync2_ff[0];
  assign tms_s = sync2_ff[1];
  assign tdi_s = sync2_ff[2];
  assign strb_s = sync2_ff[3];
  assign pin_s = sync2_ff[SW-1:4];
  assign tck_rise = tck_s & ~tck_d_ff;
  assign tck_fall = ~tck_s & tck_d_ff;
  assign strb_fall = ~strb_s & strb_d_ff;
  assign tap_rst_n = rst_n & trst_n;

  // -------------------------------------------------------------
  // TAP state machine
  // -------------------------------------------------------------
  jtp_pkg::jtp_state_t state_ff;
  jtp_pkg::jtp_state_t nxt_state;

  always_comb
  begin
    case (state_ff)
      jtp_pkg::st_tlr:
        nxt_state = tms_s ? jtp_pkg::st_tlr : jtp_pkg::st_rti;
      jtp_pkg::st_rti:
        nxt_state = tms_s ? jtp_pkg::st_sel_dr : jtp_pkg::st_rti;
      jtp_pkg::st_sel_dr:
        nxt_state = tms_s ? jtp_pkg::st_sel_ir : jtp_pkg::st_cap_dr;
      jtp_pkg::st_cap_dr:
        nxt_state = tms_s ? jtp_pkg::st_ex1_dr : jtp_pkg::st_sh_dr;
      jtp_pkg::st_sh_dr:
        nxt_state = tms_s ? jtp_pkg::st_ex1_dr : jtp_pkg::st_sh_dr;
      jtp_pkg::st_ex1_dr:
        nxt_state = tms_s ? jtp_pkg::st_upd_dr : jtp_pkg::st_pa_dr;
      jtp_pkg::st_pa_dr:
        nxt_state = tms_s ? jtp_pkg::st_ex2_dr : jtp_pkg::st_pa_dr;
      jtp_pkg::st_ex2_dr:
        nxt_state = tms_s ? jtp_pkg::st_upd_dr : jtp_pkg::st_sh_dr;
      jtp_pkg::st_upd_dr:
        nxt_state = tms_s ? jtp_pkg::st_sel_dr : jtp_pkg::st_rti;
      jtp_pkg::st_sel_ir:
        nxt_state = tms_s ? jtp_pkg::st_tlr : jtp_pkg::st_cap_ir;
      jtp_pkg::st_cap_ir:
        nxt_state = tms_s ? jtp_pkg::st_ex1_ir : jtp_pkg::st_sh_ir;
      jtp_pkg::st_sh_ir:
        nxt_state = tms_s ? jtp_pkg::st_ex1_ir : jtp_pkg::st_sh_ir;
      jtp_pkg::st_ex1_ir:
        nxt_state = tms_s ? jtp_pkg::st_upd_ir : jtp_pkg::st_pa_ir;
      jtp_pkg::st_pa_ir:
        nxt_state = tms_s ? jtp_pkg::st_ex2_ir : jtp_pkg::st_pa_ir;
      jtp_pkg::st_ex2_ir:
        nxt_state = tms_s ? jtp_pkg::st_upd_ir : jtp_pkg::st_sh_ir;
      jtp_pkg::st_upd_ir:
        nxt_state = tms_s ? jtp_pkg::st_sel_dr : jtp_pkg::st_rti;
      default:
        nxt_state = jtp_pkg::st_tlr;
    endcase
  end

  always_ff @(posedge clk or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
      state_ff <= jtp_pkg::st_tlr;
    else if (tck_rise)
      state_ff <= nxt_state;
  end

  // -------------------------------------------------------------
  // Instruction register and decode
  // -------------------------------------------------------------
  logic [`JTP_IR_W-1:0] ir_sh_ff;
  logic [`JTP_IR_W-1:0] ir_ff;
  jtp_pkg::jtp_dr_sel_t dr_sel;
  logic [5:0] dr_len;
  logic extest;

  always_ff @(posedge clk or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
    begin
      ir_sh_ff <= `JTP_IR_CAPTURE;
      ir_ff <= `JTP_OP_IDCODE;
    end
    else if (tck_rise)
    begin
      case (state_ff)
        jtp_pkg::st_tlr:
          ir_ff <= `JTP_OP_IDCODE;
        jtp_pkg::st_cap_ir:
          ir_sh_ff <= `JTP_IR_CAPTURE;
        jtp_pkg::st_sh_ir:
          ir_sh_ff <= {tdi_s, ir_sh_ff[`JTP_IR_W-1:1]};
        jtp_pkg::st_upd_ir:
          ir_ff <= ir_sh_ff;
        default:
          ir_ff <= ir_ff;
      endcase
    end
  end

  always_comb
  begin
    case (ir_ff)
      `JTP_OP_IDCODE: dr_sel = jtp_pkg::sel_id;
      `JTP_OP_USERCODE: dr_sel = jtp_pkg::sel_usr;
      `JTP_OP_EXTEST: dr_sel = jtp_pkg::sel_bsr;
      `JTP_OP_SAMPLE: dr_sel = jtp_pkg::sel_bsr;
      `JTP_OP_ROW: dr_sel = jtp_pkg::sel_row;
      `JTP_OP_COLUMN: dr_sel = jtp_pkg::sel_col;
      `JTP_OP_PMODE: dr_sel = jtp_pkg::sel_col;
      default: dr_sel = jtp_pkg::sel_byp;
    endcase
  end

  always_comb
  begin
    case (dr_sel)
      jtp_pkg::sel_id: dr_len = `JTP_ID_LEN;
      jtp_pkg::sel_usr: dr_len = `JTP_ID_LEN;
      jtp_pkg::sel_bsr: dr_len = `JTP_BSR_LEN;
      jtp_pkg::sel_row: dr_len = `JTP_ROW_LEN;
      jtp_pkg::sel_col: dr_len = `JTP_COL_LEN;
      default: dr_len = `JTP_BYP_LEN;
    endcase
  end

  assign extest = ir_ff == `JTP_OP_EXTEST;

  // -------------------------------------------------------------
  // Data register shift path
  // -------------------------------------------------------------
  logic [`JTP_DR_MAX-1:0] dr_sh_ff;
  logic [`JTP_DR_MAX-1:0] nxt_dr_sh;
  logic [`JTP_DR_MAX-1:0] dr_cap;
  logic [3*`JTP_N_IO-1:0] bsr_upd_ff;
  logic [`JTP_ROW_W-1:0] row_ff;
  logic [`JTP_COL_W-1:0] col_ff;

  always_comb
  begin
    for (int i = 0; i < `JTP_DR_MAX; i++)
    begin
      if (i == int'(dr_len) - 1)
        nxt_dr_sh[i] = tdi_s;
      else if (i < int'(dr_len) - 1)
        nxt_dr_sh[i] = dr_sh_ff[i+1];
      else
        nxt_dr_sh[i] = 1'b0;
    end
  end

  always_comb
  begin
    dr_cap = '0;
    case (dr_sel)
      jtp_pkg::sel_id: dr_cap = `JTP_IDCODE;
      jtp_pkg::sel_usr: dr_cap = `JTP_USERCODE;
      jtp_pkg::sel_bsr:
        dr_cap[3*`JTP_N_IO-1:0] = {core_oe, core_out, pin_s};
      jtp_pkg::sel_row: dr_cap[`JTP_ROW_W-1:0] = row_ff;
      jtp_pkg::sel_col: dr_cap[`JTP_COL_W-1:0] = col_ff;
      default: dr_cap = '0;
    endcase
  end

  always_ff @(posedge clk or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
      dr_sh_ff <= `JTP_IDCODE;
    else if (tck_rise && state_ff == jtp_pkg::st_cap_dr)
      dr_sh_ff <= dr_cap;
    else if (tck_rise && state_ff == jtp_pkg::st_sh_dr)
      dr_sh_ff <= nxt_dr_sh;
  end

  // -------------------------------------------------------------
  // Update stage of row, column and boundary registers
  // -------------------------------------------------------------
  logic upd_dr;

  assign upd_dr = tck_rise && state_ff == jtp_pkg::st_upd_dr;

  always_ff @(posedge clk or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
      bsr_upd_ff <= '0;
    else if (upd_dr && dr_sel == jtp_pkg::sel_bsr)
      bsr_upd_ff <= dr_sh_ff[3*`JTP_N_IO-1:0];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      row_ff <= '0;
    else if (upd_dr && dr_sel == jtp_pkg::sel_row)
      row_ff <= dr_sh_ff[`JTP_ROW_W-1:0];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      col_ff <= '0;
    else if (upd_dr && ir_ff == `JTP_OP_COLUMN)
      col_ff <= dr_sh_ff[`JTP_COL_W-1:0];
  end

  always_ff @(posedge clk or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
      prog_mode <= 1'b0;
    else if (tck_rise && state_ff == jtp_pkg::st_tlr)
      prog_mode <= 1'b0;
    else if (upd_dr && ir_ff == `JTP_OP_PMODE)
      prog_mode <= dr_sh_ff[`JTP_COL_W-1:0] == `JTP_PASSKEY;
  end

  // -------------------------------------------------------------
  // Serial output on falling edge
  // -------------------------------------------------------------
  always_ff @(posedge clk or negedge tap_rst_n)
  begin
    if (!tap_rst_n)
    begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo <= (state_ff == jtp_pkg::st_sh_ir) ? ir_sh_ff[0]
                                             : dr_sh_ff[0];
      tdo_oe <= state_ff == jtp_pkg::st_sh_ir ||
                state_ff == jtp_pkg::st_sh_dr;
    end
  end

  // -------------------------------------------------------------
  // Boundary cells between pins and core
  // -------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_out <= '0;
      pin_oe <= '0;
      core_in <= '0;
    end
    else if (extest)
    begin
      core_in <= bsr_upd_ff[`JTP_N_IO-1:0];
      pin_out <= bsr_upd_ff[2*`JTP_N_IO-1:`JTP_N_IO];
      pin_oe <= bsr_upd_ff[3*`JTP_N_IO-1:2*`JTP_N_IO];
    end
    else
    begin
      core_in <= pin_s;
      pin_out <= core_out;
      pin_oe <= core_oe;
    end
  end

  // -------------------------------------------------------------
  // Program and erase requests
  // -------------------------------------------------------------
  logic armed;
  logic req_pend_ff;
  logic req_erase_ff;
  logic fifo_ready;

  assign armed = prog_mode && (ir_ff == `JTP_OP_PROGRAM ||
                               ir_ff == `JTP_OP_ERASE);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      req_pend_ff <= 1'b0;
      req_erase_ff <= 1'b0;
    end
    else if (strb_fall && armed)
    begin
      req_pend_ff <= 1'b1;
      req_erase_ff <= ir_ff == `JTP_OP_ERASE;
    end
    else if (fifo_ready)
      req_pend_ff <= 1'b0;
  end

  jtp_fifo #(
    .WIDTH(`JTP_FIFO_W),
    .DEPTH(`JTP_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(req_pend_ff),
    .in_data({req_erase_ff, row_ff, col_ff}),
    .in_ready(fifo_ready),
    .out_valid(prog_valid),
    .out_ready(prog_ready),
    .out_data(prog_word)
  );

endmodule : jtp_tap

`default_nettype wire

//--- jtp_tap_sva.sv
// Checker for the test access port with programming registers
`timescale 1ns/1ns
`default_nettype none
`include "jtp_cfg.svh"

module jtp_tap_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Test access port
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic prog_strobe_n,
  // Device pins and core
  input wire logic [`JTP_N_IO-1:0] pin_in,
  input wire logic [`JTP_N_IO-1:0] pin_out,
  input wire logic [`JTP_N_IO-1:0] pin_oe,
  input wire logic [`JTP_N_IO-1:0] core_out,
  input wire logic [`JTP_N_IO-1:0] core_oe,
  input wire logic [`JTP_N_IO-1:0] core_in,
  // Program requests
  input wire logic prog_valid,
  input wire logic prog_ready,
  input wire logic [`JTP_FIFO_W-1:0] prog_word,
  input wire logic prog_mode
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence core_quiet_s;
    ($stable(core_out) && $stable(core_oe)) [*3];
  endsequence
  sequence strobe_fall_s;
    $fell(prog_strobe_n) && !prog_valid;
  endsequence

  trst_quiet_a: assert property (!trst_n |=> !tdo_oe && !prog_mode)
    else $error("TAP output active under test reset");
  tdo_fall_a: assert property ($changed(tdo) && trst_n && $past(trst_n)
    |-> !$past(tck)) else $error("TDO changed away from a falling TCK");
  oe_fall_a: assert property ($changed(tdo_oe) && trst_n && $past(trst_n)
    |-> !$past(tck)) else $error("TDO enable changed away from falling TCK");
  mode_on_a: assert property ($rose(prog_mode) |-> $past(tck) && trst_n)
    else $error("Program mode set without a TCK rise");
  mode_off_a: assert property ($fell(prog_mode) |-> $past(tck) || !trst_n)
    else $error("Program mode cleared without TCK rise or reset");
  valid_hold_a: assert property (prog_valid && !prog_ready
    |=> prog_valid && $stable(prog_word)) else $error("Request dropped");
  req_taken_a: assert property (prog_mode ##0 strobe_fall_s
    |-> ##[2:7] prog_valid) else $error("Armed strobe gave no request");
  req_refused_a: assert property (!prog_mode ##0 strobe_fall_s
    |=> !prog_valid [*8]) else $error("Request outside program mode");
  pins_follow_a: assert property (core_quiet_s
    |-> pin_out == core_out && pin_oe == core_oe) else $error("Pin mismatch");
  core_follow_a: assert property ($stable(pin_in) [*5] |-> core_in == pin_in)
    else $error("Core input mismatch");
endmodule : jtp_tap_sva

bind jtp_tap jtp_tap_sva jtp_tap_sva_i (.clk, .rst_n, .tck, .trst_n, .tdo,
  .tdo_oe, .prog_strobe_n, .pin_in, .pin_out, .pin_oe, .core_out, .core_oe,
  .core_in, .prog_valid, .prog_ready, .prog_word, .prog_mode);

`default_nettype wire

//--- jtp_tap_tb.sv
// Testbench of the test access port with programming registers
`timescale 1ns/1ns
`default_nettype none
`include "jtp_cfg.svh"

module jtp_tap_tb;
  logic clk, rst_n, prog_strobe_n, prog_ready;
  logic [`JTP_N_IO-1:0] pin_in, core_out, core_oe;
  wire logic tck, tms, tdi, trst_n, tdo, tdo_oe, prog_valid, prog_mode;
  wire logic [`JTP_N_IO-1:0] pin_out, pin_oe, core_in;
  wire logic [`JTP_FIFO_W-1:0] prog_word;
  logic [31:0] st = 32'hE75C99B3;
  logic [31:0] d1, d2, q;
  logic [5:0] ops [6] = '{`JTP_OP_IDCODE, `JTP_OP_USERCODE, `JTP_OP_ROW,
    `JTP_OP_COLUMN, `JTP_OP_BYPASS, 6'h2A};
  int n_fail = 0;
  int samples_checked = 0;

  jtp_tap jtp_tap_i (.clk, .rst_n, .tck, .tms, .tdi, .trst_n, .tdo, .tdo_oe,
    .prog_strobe_n, .pin_in, .pin_out, .pin_oe, .core_out, .core_oe,
    .core_in, .prog_valid, .prog_ready, .prog_word, .prog_mode);
  jtp_tester jtp_tester_i (.tck, .tms, .tdi, .trst_n, .tdo);

  function automatic logic [31:0] rnd();
    st = {st[30:0], st[31] ^ st[21] ^ st[1] ^ st[0]};
    return st;
  endfunction : rnd

  function automatic int dr_len(logic [5:0] op);
    case (op)
      `JTP_OP_COLUMN: return 16;
      `JTP_OP_IDCODE, `JTP_OP_USERCODE: return 32;
      default: return 8;
    endcase
  endfunction : dr_len

  // Value read by the second of two scans
  function automatic logic [31:0] dr_exp(logic [5:0] op, logic [31:0] a,
    logic [31:0] b);
    case (op)
      `JTP_OP_IDCODE: return `JTP_IDCODE;
      `JTP_OP_USERCODE: return `JTP_USERCODE;
      `JTP_OP_ROW: return {24'h00_0000, a[7:0]};
      `JTP_OP_COLUMN: return {16'h0000, a[15:0]};
      default: return {24'h00_0000, b[6:0], 1'b0};
    endcase
  endfunction : dr_exp

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("Checked %0d, failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic ir(input logic [5:0] op, output logic [31:0] o);
    jtp_tester_i.scan(1'b1, 6, {26'h000_0000, op}, o);
  endtask : ir

  task automatic dr(input int n, input logic [31:0] d);
    jtp_tester_i.scan(1'b0, n, d, q);
  endtask : dr

  task automatic strobe();
    @(posedge clk);
    #1 prog_strobe_n = 1'b0;
    repeat (8) @(posedge clk);
    #1 prog_strobe_n = 1'b1;
    repeat (8) @(posedge clk);
    #1;
  endtask : strobe

  // Take n requests, array always ready
  task automatic drain(input int n, input logic [`JTP_FIFO_W-1:0] w);
    int got;
    got = 0;
    @(posedge clk);
    #1 prog_ready = 1'b1;
    for (int t = 0; t < 400 && got < n; t++)
    begin
      #1;
      if (prog_valid === 1'b1)
      begin
        check(prog_word, w);
        got++;
      end
      @(posedge clk);
    end
    #1 prog_ready = 1'b0;
    check(got, n);
    if (got != n)
      give_verdict();
  endtask : drain

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    rst_n = 1'b0;
    prog_strobe_n = 1'b1;
    prog_ready = 1'b0;
    {core_oe, core_out, pin_in} = 12'h000;
    repeat (16) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1 jtp_tester_i.tck_cyc(1'b0, 1'b0, q[0]);
    dr(32, rnd());
    check(q, `JTP_IDCODE);
    $display("Test power-up done");
    foreach (ops[k])
    begin
      ir(ops[k], q);
      check(q, 32'h0000_0001);
      d1 = rnd();
      d2 = rnd();
      dr(dr_len(ops[k]), d1);
      dr(dr_len(ops[k]), d2);
      check(q, dr_exp(ops[k], d1, d2));
    end
    $display("Test data registers done");
    @(posedge clk);
    d1 = rnd();
    #1 {core_oe, core_out, pin_in} = d1[11:0];
    ir(`JTP_OP_SAMPLE, q);
    dr(12, rnd());
    check(q, {20'h0_0000, core_oe, core_out, pin_in});
    $display("Test boundary done");
    ir(`JTP_OP_USERCODE, q);
    for (int i = 0; i < 6; i++)
      jtp_tester_i.tck_cyc(i < 1, 1'b1, q[0]);
    jtp_tester_i.reset5();
    dr(32, rnd());
    check(q, `JTP_IDCODE);
    ir(`JTP_OP_USERCODE, q);
    jtp_tester_i.trst_pulse();
    dr(32, rnd());
    check(q, `JTP_IDCODE);
    $display("Test resets done");
    ir(`JTP_OP_PMODE, q);
    dr(16, 32'h0000_5A5A);
    check(prog_mode, 1'b0);
    ir(`JTP_OP_PROGRAM, q);
    strobe();
    check(prog_valid, 1'b0);
    d1 = rnd();
    ir(`JTP_OP_ROW, q);
    dr(8, d1);
    ir(`JTP_OP_COLUMN, q);
    dr(16, d1 >> 8);
    ir(`JTP_OP_PMODE, q);
    dr(16, `JTP_PASSKEY);
    check(prog_mode, 1'b1);
    ir(`JTP_OP_PROGRAM, q);
    repeat (17) strobe();
    check(prog_valid, 1'b1);
    drain(17, {1'b0, d1[7:0], d1[23:8]});
    ir(`JTP_OP_ERASE, q);
    strobe();
    drain(1, {1'b1, d1[7:0], d1[23:8]});
    $display("Test programming done");
    give_verdict();
  end
endmodule : jtp_tap_tb

`default_nettype wire

//--- jtp_tester.sv
// Boundary-scan tester model driving the test access port
`timescale 1ns/1ns
`default_nettype none

module jtp_tester (
  // Test access port
  output var logic tck,
  output var logic tms,
  output var logic tdi,
  output var logic trst_n,
  input wire logic tdo
);
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b1;
  end

  // One test clock, idle low between frames
  task automatic tck_cyc(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #160 tck = 1'b1;
    #100 o = tdo;
    #60 tck = 1'b0;
  endtask : tck_cyc

  // Reset by TMS alone, then idle
  task automatic reset5();
    logic o;
    repeat (5) tck_cyc(1'b1, 1'b0, o);
    tck_cyc(1'b0, 1'b0, o);
  endtask : reset5

  task automatic trst_pulse();
    logic o;
    trst_n = 1'b0;
    repeat (3) tck_cyc(1'b0, 1'b0, o);
    trst_n = 1'b1;
    tck_cyc(1'b0, 1'b0, o);
  endtask : trst_pulse

  // Full scan from idle, LSB first, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
    output logic [31:0] dout);
    logic o;
    dout = 32'h0000_0000;
    tck_cyc(1'b1, 1'b0, o);
    if (ir)
      tck_cyc(1'b1, 1'b0, o);
    tck_cyc(1'b0, 1'b0, o);
    tck_cyc(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++)
    begin
      tck_cyc(i == n - 1, din[i], o);
      dout[i] = o;
    end
    tck_cyc(1'b1, 1'b0, o);
    tck_cyc(1'b0, 1'b0, o);
  endtask : scan
endmodule : jtp_tester

`default_nettype wire
